// *** pkg/fxa_pkg.sv ***
// Constants and types for the fixed-point arithmetic datapath.
// Assumes a single clock domain and the plain register port of the top.
package fxa_pkg;
    // Operand formats
    localparam int WORD_W = 36;
    localparam int MAG_W = 35;
    localparam int ACC_MAG_W = 37;
    localparam int DIV_MAG_W = 72;
    localparam int SIGN_POS = 35;
    localparam int STEP_W = 6;
    localparam logic [5:0] MUL_STEPS = 6'h23;
    localparam logic [5:0] DIV_STEPS = 6'h23;

    // Register offsets
    localparam logic [3:0] A_SR = 4'h0;
    localparam logic [3:0] A_ACC_LO = 4'h1;
    localparam logic [3:0] A_ACC_HI = 4'h2;
    localparam logic [3:0] A_MQ = 4'h3;
    localparam logic [3:0] A_CMD = 4'h4;
    localparam logic [3:0] A_STAT = 4'h5;
    localparam logic [3:0] A_CMP = 4'h6;

    // Command codes
    localparam logic [2:0] C_ADD = 3'h1;
    localparam logic [2:0] C_SUB = 3'h2;
    localparam logic [2:0] C_MUL = 3'h3;
    localparam logic [2:0] C_DIV = 3'h4;
    localparam logic [2:0] C_CMP = 3'h5;

    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_OVF = 1;
    localparam int ST_QC = 2;
    localparam int ST_EQ = 3;
    localparam int ST_DCK = 4;

    typedef enum logic [2:0] {
        FXA_IDLE, FXA_FIX, FXA_MUL, FXA_DIV, FXA_CMP2
    } fxa_state_t;
endpackage

// *** pkg/fxa_add_if.sv ***
// Carrier between the datapath control and its complement adder.
// Assumes the adder is pure combinational logic.
`timescale 1ns/1ps
interface fxa_add_if;
    import fxa_pkg::*;
    logic [ACC_MAG_W-1:0] a;
    logic [ACC_MAG_W-1:0] b;
    logic comp_b;
    logic cin;
    logic [ACC_MAG_W-1:0] sum;
    logic q_carry;
    modport ctl (output a, b, comp_b, cin, input sum, q_carry);
    modport add (input a, b, comp_b, cin, output sum, q_carry);
endinterface

// *** logic/fxa_adder.sv ***
// Complement adder of the datapath: the only arithmetic element.
// Assumes operands arrive already widened to the accumulator value field.
`timescale 1ns/1ps
module fxa_adder
    import fxa_pkg::*;
(
    // Adder operands and result
    fxa_add_if.add bus
);
    logic [ACC_MAG_W:0] total;
    logic [ACC_MAG_W-1:0] b_in;

    always_comb
    begin
        // Ones' complement is a plain inversion of every bit
        b_in = bus.comp_b ? ~bus.b : bus.b;
        // Twos' complement is the inversion plus a low-order carry in
        total = {1'b0, bus.a} + {1'b0, b_in}
            + {{ACC_MAG_W{1'b0}}, bus.cin};
        bus.sum = total[ACC_MAG_W-1:0];
        bus.q_carry = total[ACC_MAG_W];
    end
endmodule

// *** logic/fxa_regs.sv ***
// Read multiplexer of the register port, registered one cycle.
// Assumes the caller presents every register as a flat 36-bit word.
`timescale 1ns/1ps
module fxa_regs
    import fxa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Request
    input wire logic rd,
    input wire logic [3:0] addr,
    // Register values
    input wire logic [WORD_W-1:0] sr,
    input wire logic [WORD_W-1:0] acc_lo,
    input wire logic [WORD_W-1:0] acc_hi,
    input wire logic [WORD_W-1:0] mq,
    input wire logic [WORD_W-1:0] stat,
    // Answer
    output logic [WORD_W-1:0] rdata
);
    typedef struct packed {
        logic [WORD_W-1:0] rdata;
    } fxa_rd_t;
    fxa_rd_t r;
    fxa_rd_t next_r;

    always_comb
    begin
        next_r = r;
        if (rd)
        begin
            case (addr)
                A_SR: next_r.rdata = sr;
                A_ACC_LO: next_r.rdata = acc_lo;
                A_ACC_HI: next_r.rdata = acc_hi;
                A_MQ: next_r.rdata = mq;
                A_STAT: next_r.rdata = stat;
                default: next_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign rdata = r.rdata;
endmodule

// *** logic/fxa_datapath.sv ***
// Fixed-point add, subtract, multiply, divide and compare datapath.
// Assumes software loads the storage register with the addressed word and
// polls the busy bit before issuing the next command.
`timescale 1ns/1ps
module fxa_datapath
    import fxa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [WORD_W-1:0] rdata,
    // Status
    output logic busy,
    output logic overflow
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        fxa_state_t st;
        logic [WORD_W-1:0] sr;
        logic acc_sign;
        logic [ACC_MAG_W-1:0] acc;
        logic [WORD_W-1:0] mq;
        logic [STEP_W-1:0] step;
        logic ovf;
        logic qc;
        logic eq;
        logic div_chk;
        logic twos;
        logic qc_twos;
        logic busy;
    } fxa_dp_t;
    fxa_dp_t r;
    fxa_dp_t next_r;

    fxa_add_if add_bus();

    fxa_adder u_adder (
        .bus(add_bus)
    );

    function automatic logic [ACC_MAG_W-1:0] widen(
        input logic [MAG_W-1:0] m
    );
        widen = {2'b00, m};
    endfunction

    logic [MAG_W-1:0] sr_mag;
    logic [MAG_W-1:0] mq_mag;
    logic [ACC_MAG_W-1:0] div_shift;
    logic [WORD_W-1:0] stat_word;
    logic cmd_sign;

    assign sr_mag = r.sr[MAG_W-1:0];
    assign mq_mag = r.mq[MAG_W-1:0];
    // Dividend shifted left one place: top of MQ value enters the acc
    assign div_shift = {r.acc[ACC_MAG_W-2:0], mq_mag[MAG_W-1]};

    // ************************************************************
    // Adder operand selection
    // ************************************************************
    always_comb
    begin
        add_bus.a = r.acc;
        add_bus.b = widen(sr_mag);
        add_bus.comp_b = 1'b0;
        add_bus.cin = 1'b0;
        cmd_sign = 1'b0;
        case (r.st)
            FXA_IDLE:
            begin
                // Both operands gated in together on command
                add_bus.a = r.acc;
                add_bus.b = widen(sr_mag);
                cmd_sign = (wdata[2:0] == C_SUB) ? ~r.sr[SIGN_POS]
                    : r.sr[SIGN_POS];
                if ((wdata[2:0] == C_CMP))
                begin
                    // First compare pass in ones' complement
                    add_bus.comp_b = 1'b1;
                    add_bus.cin = 1'b0;
                end
                else if (cmd_sign != r.acc_sign)
                begin
                    // Unlike signs: complemented acc plus storage operand
                    add_bus.a = widen(sr_mag);
                    add_bus.b = r.acc;
                    add_bus.comp_b = 1'b1;
                end
            end
            FXA_FIX:
            begin
                // Correcting pass: add one or recomplement
                add_bus.a = '0;
                add_bus.b = r.acc;
                add_bus.comp_b = ~r.qc;
                add_bus.cin = r.qc;
            end
            FXA_CMP2:
            begin
                // Second compare pass in twos' complement
                add_bus.comp_b = 1'b1;
                add_bus.cin = 1'b1;
            end
            FXA_MUL:
            begin
                add_bus.a = r.acc;
                add_bus.b = widen(sr_mag);
            end
            FXA_DIV:
            begin
                // Trial subtraction in twos' complement
                add_bus.a = div_shift;
                add_bus.b = widen(sr_mag);
                add_bus.comp_b = 1'b1;
                add_bus.cin = 1'b1;
            end
            default:
            begin
                add_bus.a = r.acc;
            end
        endcase
    end

    // ************************************************************
    // Sequencing
    // ************************************************************
    always_comb
    begin
        next_r = r;
        case (r.st)
            FXA_IDLE:
            begin
                if (wr && addr == A_SR)
                    next_r.sr = wdata;
                else if (wr && addr == A_ACC_LO)
                begin
                    next_r.acc_sign = wdata[SIGN_POS];
                    next_r.acc[MAG_W-1:0] = wdata[MAG_W-1:0];
                end
                else if (wr && addr == A_ACC_HI)
                    next_r.acc[ACC_MAG_W-1:MAG_W] = wdata[1:0];
                else if (wr && addr == A_MQ)
                    next_r.mq = wdata;
                else if (wr && addr == A_CMD)
                begin
                    case (wdata[2:0])
                        C_ADD, C_SUB:
                        begin
                            next_r.acc = add_bus.sum;
                            next_r.qc = add_bus.q_carry;
                            if (cmd_sign == r.acc_sign)
                            begin
                                next_r.acc_sign = cmd_sign;
                                // Either overflow bit set means overflow
                                if (add_bus.sum[ACC_MAG_W-1:MAG_W] != 2'b00)
                                    next_r.ovf = 1'b1;
                            end
                            else
                            begin
                                next_r.st = FXA_FIX;
                                next_r.busy = 1'b1;
                            end
                        end
                        C_MUL:
                        begin
                            next_r.acc = '0;
                            next_r.step = '0;
                            next_r.st = FXA_MUL;
                            next_r.busy = 1'b1;
                        end
                        C_DIV:
                        begin
                            next_r.step = '0;
                            next_r.div_chk = 1'b0;
                            next_r.st = FXA_DIV;
                            next_r.busy = 1'b1;
                        end
                        C_CMP:
                        begin
                            next_r.qc = add_bus.q_carry;
                            next_r.st = FXA_CMP2;
                            next_r.busy = 1'b1;
                        end
                        default:
                        begin
                            next_r.st = FXA_IDLE;
                        end
                    endcase
                end
            end
            FXA_FIX:
            begin
                // Carry: true form, one short; flip sign. Else recomplement
                next_r.acc = add_bus.sum;
                if (r.qc)
                    next_r.acc_sign = ~r.acc_sign;
                next_r.st = FXA_IDLE;
                next_r.busy = 1'b0;
            end
            FXA_CMP2:
            begin
                // Twos' carry with no ones' carry flags equal operands
                next_r.qc_twos = add_bus.q_carry;
                next_r.eq = add_bus.q_carry & ~r.qc;
                next_r.st = FXA_IDLE;
                next_r.busy = 1'b0;
            end
            FXA_MUL:
            begin
                // Add when multiplier low bit set, then shift right
                if (r.mq[0])
                    {next_r.acc, next_r.mq[MAG_W-1:0]} =
                        {add_bus.sum, mq_mag} >> 1;
                else
                    {next_r.acc, next_r.mq[MAG_W-1:0]} =
                        {r.acc, mq_mag} >> 1;
                next_r.step = r.step + 6'h01;
                if (r.step == MUL_STEPS - 6'h01)
                begin
                    // Sign of product into both sign positions
                    next_r.acc_sign = r.sr[SIGN_POS] ^ r.mq[SIGN_POS];
                    next_r.mq[SIGN_POS] = r.sr[SIGN_POS]
                        ^ r.mq[SIGN_POS];
                    next_r.st = FXA_IDLE;
                    next_r.busy = 1'b0;
                end
            end
            FXA_DIV:
            begin
                // Dividend is acc:mq value, 72 bits; quotient bits enter mq
                next_r.mq[MAG_W-1:0] = {mq_mag[MAG_W-2:0],
                    add_bus.q_carry};
                next_r.acc = add_bus.q_carry ? add_bus.sum : div_shift;
                // A divisor not above the shifted high dividend (acc doubled plus top MQ bit) flags divide check
                if (r.step == '0 && add_bus.q_carry)
                    next_r.div_chk = 1'b1;
                next_r.step = r.step + 6'h01;
                if (r.step == DIV_STEPS - 6'h01)
                begin
                    // Quotient in divisor format; remainder keeps its sign
                    next_r.mq[SIGN_POS] = r.sr[SIGN_POS]
                        ^ r.acc_sign;
                    next_r.st = FXA_IDLE;
                    next_r.busy = 1'b0;
                end
            end
            default:
            begin
                next_r.st = FXA_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            r <= '{st: FXA_IDLE, default: '0};
        else
            r <= next_r;
    end

    // ************************************************************
    // Register read-back
    // ************************************************************
    assign stat_word = {{(WORD_W-6){1'b0}}, r.qc_twos, r.div_chk, r.eq,
        r.qc, r.ovf, r.busy};

    fxa_regs u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .rd(rd),
        .addr(addr),
        .sr(r.sr),
        .acc_lo({r.acc_sign, r.acc[MAG_W-1:0]}),
        .acc_hi({{(WORD_W-2){1'b0}}, r.acc[ACC_MAG_W-1:MAG_W]}),
        .mq(r.mq),
        .stat(stat_word),
        .rdata(rdata)
    );

    assign busy = r.busy;
    assign overflow = r.ovf;
endmodule

// *** verification/fxa_datapath_props.sv ***
// Concurrent checks on the ports of the fixed-point datapath top.
// Assumes the command code sits in the low three bits of a command write.
`timescale 1ns/1ps
module fxa_datapath_props
    import fxa_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [WORD_W-1:0] rdata,
    // Status
    input wire logic busy,
    input wire logic overflow
);
    // ****************
    // Helper state
    // ****************
    logic [5:0] bcnt;
    logic sr_s;
    logic acc_s;
    logic mq_s;
    logic last_mul;
    logic last_fix;
    logic sgn_ok;
    logic exp_sgn;
    logic go;
    logic addsub;
    logic like;
    logic [2:0] op;

    assign op = wdata[2:0];
    assign go = wr && !busy && addr == A_CMD;
    assign addsub = op == C_ADD || op == C_SUB;
    assign like = (op == C_SUB) ^ (sr_s == acc_s);

    // Writes during busy are dropped, so they never move the tracked signs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bcnt <= 6'h0;
            {sr_s, acc_s, mq_s, last_mul, last_fix, sgn_ok, exp_sgn} <= 7'h0;
        end
        else
        begin
            bcnt <= busy ? bcnt + 6'h1 : 6'h0;
            if (wr && !busy)
            begin
                if (addr == A_SR)
                    sr_s <= wdata[SIGN_POS];
                if (addr == A_ACC_LO)
                    acc_s <= wdata[SIGN_POS];
                if (addr == A_MQ)
                    mq_s <= wdata[SIGN_POS];
                sgn_ok <= go && (op == C_MUL || op == C_DIV);
                last_mul <= go && op == C_MUL;
                exp_sgn <= sr_s ^ (op == C_MUL ? mq_s : acc_s);
            end
            if (go)
                last_fix <= addsub;
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_mul_busy_len: assert property (
        $fell(busy) && last_mul |-> bcnt == MUL_STEPS)
        else $error("multiply busy length wrong");
    chk_mul_start: assert property (
        go && op == C_MUL |=> busy [*8])
        else $error("multiply did not hold busy");
    chk_div_start: assert property (
        go && op == C_DIV |=> busy [*8])
        else $error("divide did not hold busy");
    chk_like_one_pass: assert property (
        go && addsub && like |=> !busy [*2])
        else $error("like-sign add took a second pass");
    chk_unlike_two_pass: assert property (
        go && addsub && !like |=> busy ##1 !busy)
        else $error("unlike-sign add pass count wrong");
    chk_busy_cause: assert property (
        $rose(busy) |-> $past(go))
        else $error("busy rose without a command");
    chk_ovf_sticky: assert property (
        overflow |=> overflow)
        else $error("overflow cleared without reset");
    chk_ovf_cause: assert property (
        $rose(overflow) |-> last_fix)
        else $error("overflow rose outside add or subtract");
    chk_stat_mirror: assert property (
        rd && addr == A_STAT |=> rdata[ST_OVF] == $past(overflow)
            && rdata[ST_BUSY] == $past(busy))
        else $error("status read disagrees with status pins");
    chk_quot_sign: assert property (
        rd && !busy && addr == A_MQ && sgn_ok |=> rdata[SIGN_POS] == exp_sgn)
        else $error("product or quotient sign wrong");
    chk_prod_acc_sign: assert property (
        rd && !busy && addr == A_ACC_LO && sgn_ok && last_mul
            |=> rdata[SIGN_POS] == exp_sgn)
        else $error("product sign missing from accumulator");

    cov_mul_done: cover property ($fell(busy) && last_mul);
    cov_div_go: cover property (go && op == C_DIV);
    cov_ovf: cover property ($rose(overflow));
endmodule

bind fxa_datapath fxa_datapath_props u_props (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .busy(busy), .overflow(overflow)
);

// *** verification/tb_top.sv ***
// Self-checking bench driving the datapath through its register port.
// Assumes command codes in the low bits and the checker bound alongside.
`timescale 1ns/1ps
module tb_top;
    import fxa_pkg::*;

    typedef struct {
        logic [2:0] cmd;
        logic [35:0] sr;
        logic [35:0] acc;
        logic [35:0] mq;
        logic [35:0] e_acc;
        logic [35:0] e_mq;
        logic [5:0] e_st;
        logic [5:0] msk;
    } fxa_row_t;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [35:0] wdata = 36'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [35:0] rdata;
    logic busy;
    logic overflow;
    logic [35:0] d;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    fxa_row_t rows [16];
    fxa_row_t r;

    always #4 clk = ~clk;

    fxa_datapath DUT (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .overflow(overflow)
    );

    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [35:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [35:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic load(input fxa_row_t x);
        wr_reg(A_SR, x.sr);
        wr_reg(A_ACC_LO, x.acc);
        wr_reg(A_ACC_HI, 36'h0);
        wr_reg(A_MQ, x.mq);
        wr_reg(A_CMD, {33'h0, x.cmd});
    endtask

    // Bounded poll; a hang counts as a mismatch
    task automatic wait_done();
        int n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 60)
            check(36'h1, 36'h0);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // ****************
    // Stimulus
    // ****************
    initial
    begin
        rows[0] = '{C_ADD, 36'h80, 36'h3d, 0, 36'hbd, 0, 0, 6'h13};
        rows[1] = '{C_ADD, 36'h80, 36'h8_0000_003d, 0, 36'h43, 0, 0, 6'h13};
        rows[2] = '{C_ADD, 36'h3d, 36'h8_0000_0080, 0, 36'h8_0000_0043,
            0, 0, 6'h13};
        rows[3] = '{C_ADD, 36'h3d, 36'h8_0000_003d, 0, 36'h8_0000_0000,
            0, 0, 6'h13};
        rows[4] = '{C_SUB, 36'h3d, 36'h80, 0, 36'h43, 0, 0, 6'h13};
        rows[5] = '{C_SUB, 36'h8_0000_003d, 36'h80, 0, 36'hbd, 0, 0, 6'h13};
        rows[6] = '{C_SUB, 36'h80, 36'h3d, 0, 36'h8_0000_0043, 0, 0, 6'h13};
        rows[7] = '{C_MUL, 36'h4_0000_0000, 0, 36'h4, 36'h2, 0, 0, 6'h13};
        rows[8] = '{C_MUL, 36'hc_0000_0000, 0, 36'h4, 36'h8_0000_0002,
            36'h8_0000_0000, 0, 6'h13};
        rows[9] = '{C_DIV, 36'h8_0000_0007, 0, 36'h64, 36'h2,
            36'h8_0000_000e, 0, 6'h13};
        rows[10] = '{C_DIV, 36'h3, 36'h8_0000_0001, 0, 36'h8_0000_0002,
            36'ha_aaaa_aaaa, 0, 6'h13};
        rows[11] = '{C_CMP, 36'h2d, 36'h2d, 0, 36'h2d, 0, 6'h28, 6'h2f};
        rows[12] = '{C_CMP, 36'h24, 36'h2d, 0, 36'h2d, 0, 6'h24, 6'h2f};
        rows[13] = '{C_CMP, 36'h8_0000_002d, 36'h2d, 0, 36'h2d, 0,
            6'h28, 6'h2f};
        rows[14] = '{C_ADD, 36'h8_0000_0080, 36'h8_0000_003d, 0,
            36'h8_0000_00bd, 0, 0, 6'h13};
        rows[15] = '{C_SUB, 36'h3d, 36'h3d, 0, 36'h0, 0, 0, 6'h13};
        repeat (4) @(posedge clk);
        check({34'h0, busy, overflow}, 36'h0);
        reset_n <= 1'b1;
        rd_reg(A_STAT, d);
        check({30'h0, d[5:0]}, 36'h0);
        rd_reg(4'hf, d);
        check(d, 36'h0);
        foreach (rows[i])
        begin
            r = rows[i];
            load(r);
            wait_done();
            rd_reg(A_ACC_LO, d);
            check(d, r.e_acc);
            rd_reg(A_MQ, d);
            check(d, r.e_mq);
            rd_reg(A_ACC_HI, d);
            check({34'h0, d[1:0]}, 36'h0);
            rd_reg(A_STAT, d);
            check({30'h0, d[5:0] & r.msk}, {30'h0, r.e_st});
            if (r.cmd == C_CMP && !r.e_st[ST_EQ])
                check({35'h0, d[ST_QC]}, {35'h0, d[5]});
        end
        // Writes landing mid-multiply must be dropped
        load(rows[7]);
        wr_reg(A_SR, 36'h123);
        wr_reg(A_CMD, {33'h0, C_ADD});
        wait_done();
        rd_reg(A_SR, d);
        check(d, 36'h4_0000_0000);
        rd_reg(A_ACC_LO, d);
        check(d, 36'h2);
        // Divisor equal to the high dividend, below its shifted value, must set divide check
        load('{C_DIV, 36'h3, 36'h3, 0, 0, 0, 0, 0});
        wait_done();
        rd_reg(A_STAT, d);
        check({35'h0, d[ST_DCK]}, 36'h1);
        // Largest magnitude plus one carries into the lower overflow bit
        load('{C_ADD, 36'h7_ffff_ffff, 36'h1, 0, 0, 0, 0, 0});
        wait_done();
        rd_reg(A_ACC_HI, d);
        check({34'h0, d[1:0]}, 36'h1);
        rd_reg(A_ACC_LO, d);
        check(d, 36'h0);
        check({35'h0, overflow}, 36'h1);
        load(rows[1]);
        wait_done();
        check({35'h0, overflow}, 36'h1);
        // Only a reset clears the sticky overflow
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        check({34'h0, busy, overflow}, 36'h0);
        reset_n <= 1'b1;
        rd_reg(A_ACC_LO, d);
        check(d, 36'h0);
        give_verdict();
    end
endmodule
